// file: common/ppmc_map.svh
// offsets, control word fields and reset values of the parallel port block
// assumes: included by its bare name from the package and bench files
`ifndef PPMC_MAP_SVH
`define PPMC_MAP_SVH

// host register offsets on the 5-bit host address
`define PPMC_OFS_FIRST      5'h00
`define PPMC_OFS_SECOND     5'h01
`define PPMC_OFS_THIRD      5'h02
`define PPMC_OFS_MODE       5'h03
`define PPMC_OFS_IRQ_EN     5'h14
`define PPMC_OFS_IRQ_GATE   5'h15

// control word fields
`define PPMC_CW_FLAG        7
`define PPMC_CW_A_MODE_HI   6
`define PPMC_CW_A_MODE_LO   5
`define PPMC_CW_A_IN        4
`define PPMC_CW_CU_IN       3
`define PPMC_CW_B_MODE      2
`define PPMC_CW_B_IN        1
`define PPMC_CW_CL_IN       0
`define PPMC_BSR_SEL_HI     3
`define PPMC_BSR_SEL_LO     1
`define PPMC_BSR_VAL        0

// interrupt control fields
`define PPMC_EN_A_BIT       0
`define PPMC_EN_B_BIT       1
`define PPMC_GIE_BIT        2

// third-port handshake line positions
`define PPMC_PC_A_OBF       7
`define PPMC_PC_A_ACK       6
`define PPMC_PC_A_IBF       5
`define PPMC_PC_A_STB       4
`define PPMC_PC_A_INTR      3
`define PPMC_PC_B_STB       2
`define PPMC_PC_B_BUF       1
`define PPMC_PC_B_INTR      0

// reset values: basic mode, every section input
`define PPMC_MODE_RESET     8'h9b
`define PPMC_BYTE_ZERO      8'h00

`endif

// file: common/ppmc_pkg.sv
// types shared by the parallel port core and its handshake group
// assumes: ppmc_map.svh is on the include path
package ppmc_pkg;
  `include "ppmc_map.svh"

  // operating mode of a group
  typedef enum logic [1:0] {
    PPMC_BASIC,
    PPMC_STROBED,
    PPMC_BIDIR
  } ppmc_mode_t;

  // state of one handshake group
  typedef struct packed {
    logic       ibf;
    logic       obf;
    logic       out_done;
    logic       intr;
    logic [7:0] lat;
  } ppmc_hs_state_t;

  // state of the core
  typedef struct packed {
    logic [1:0] wr_s;
    logic       wr_d;
    logic [1:0] rd_s;
    logic       rd_d;
    logic [4:0] addr_s1;
    logic [4:0] addr_s2;
    logic [7:0] wdat_s1;
    logic [7:0] wdat_s2;
    logic [4:0] cap_addr;
    logic [7:0] cap_data;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pb_s1;
    logic [7:0] pb_s2;
    logic [7:0] pc_s1;
    logic [7:0] pc_s2;
    logic [7:0] pc_d;
    logic [7:0] mode_word;
    logic [7:0] out_a;
    logic [7:0] out_b;
    logic [7:0] out_c;
    logic [1:0] port_irq_en;
    logic       global_irq_enable;
    logic [7:0] host_rdata;
    logic       host_rdata_oe;
    logic       host_irq;
    logic [7:0] pa_out;
    logic       pa_oe;
    logic [7:0] pb_out;
    logic       pb_oe;
    logic [7:0] pc_out;
    logic [7:0] pc_oe;
  } ppmc_core_state_t;
endpackage

// file: common/ppmc_hs_if.sv
// signals between the core and one handshake group
// assumes: one instance per group, all on mclk
`timescale 1ns/1ps
interface ppmc_hs_if;
  logic       en_in;
  logic       en_out;
  logic       inte_in;
  logic       inte_out;
  logic       stb_fall;
  logic       ack_fall;
  logic       rd_pulse;
  logic       wr_pulse;
  logic [7:0] pin_data;
  logic       ibf;
  logic       obf;
  logic       intr;
  logic [7:0] lat;

  modport core (
    output en_in, en_out, inte_in, inte_out, stb_fall, ack_fall,
    output rd_pulse, wr_pulse, pin_data,
    input  ibf, obf, intr, lat
  );
  modport grp (
    input  en_in, en_out, inte_in, inte_out, stb_fall, ack_fall,
    input  rd_pulse, wr_pulse, pin_data,
    output ibf, obf, intr, lat
  );
endinterface // ppmc_hs_if

// file: logic/ppmc_hs_group.sv
// one strobed handshake group: input latch, buffer flags, request
// assumes: strobe, acknowledge and host pulses are one-cycle on mclk
`timescale 1ns/1ps
module ppmc_hs_group
  import ppmc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  ppmc_hs_if.grp   hs
);

  ppmc_hs_state_t r;
  ppmc_hs_state_t next_r;

  // flag updates, the setting event wins over the clearing one
  always_comb begin
    next_r = r;
    if (hs.rd_pulse) begin
      next_r.ibf = 1'b0;
    end
    if (hs.en_in && hs.stb_fall) begin
      next_r.ibf = 1'b1;
      next_r.lat = hs.pin_data;
    end
    if (hs.ack_fall) begin
      next_r.obf = 1'b0;
    end
    if (hs.wr_pulse) begin
      next_r.out_done = 1'b0;
    end
    if (hs.en_out && hs.ack_fall && r.obf) begin
      next_r.out_done = 1'b1;
    end
    if (hs.en_out && hs.wr_pulse) begin
      next_r.obf = 1'b1;
    end
    if (!hs.en_in) begin
      next_r.ibf = 1'b0;
    end
    if (!hs.en_out) begin
      next_r.obf      = 1'b0;
      next_r.out_done = 1'b0;
    end
    // request from full input latch or emptied output latch
    next_r.intr = (hs.en_in && next_r.ibf && hs.inte_in) ||
                  (hs.en_out && next_r.out_done && hs.inte_out);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign hs.ibf  = r.ibf;
  assign hs.obf  = r.obf;
  assign hs.intr = r.intr;
  assign hs.lat  = r.lat;

endmodule // ppmc_hs_group

// file: logic/ppmc_core.sv
// parallel port core: host register port, mode decode, pins and interrupt gate
// assumes: host strobes and all port pins are asynchronous to mclk (40 MHz)
`timescale 1ns/1ps
module ppmc_core
  import ppmc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [4:0] host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_wr_n,
  input  wire logic       host_rd_n,
  output logic [7:0]      host_rdata,
  output logic            host_rdata_oe,
  output logic            host_irq,
  input  wire logic [7:0] pa_in,
  output logic [7:0]      pa_out,
  output logic            pa_oe,
  input  wire logic [7:0] pb_in,
  output logic [7:0]      pb_out,
  output logic            pb_oe,
  input  wire logic [7:0] pc_in,
  output logic [7:0]      pc_out,
  output logic [7:0]      pc_oe
);

  ppmc_core_state_t r;
  ppmc_core_state_t next_r;
  ppmc_hs_if        hs[2] ();

  // decode of the first group's mode field
  function automatic ppmc_mode_t mode_of_a(input logic [7:0] cw);
    if (cw[`PPMC_CW_A_MODE_HI]) begin
      return PPMC_BIDIR;
    end else if (cw[`PPMC_CW_A_MODE_LO]) begin
      return PPMC_STROBED;
    end else begin
      return PPMC_BASIC;
    end
  endfunction

  // decode of the second group's mode field, no bidirectional choice
  function automatic ppmc_mode_t mode_of_b(input logic [7:0] cw);
    if (cw[`PPMC_CW_B_MODE]) begin
      return PPMC_STROBED;
    end else begin
      return PPMC_BASIC;
    end
  endfunction

  ppmc_mode_t mode_a;
  ppmc_mode_t mode_b;
  logic       a_in;
  logic       b_in;
  logic       cu_in;
  logic       cl_in;
  logic       wr_end;
  logic       rd_end;
  logic [7:0] pc_fall;
  logic [7:0] hs_mask;
  logic [7:0] hs_out;
  logic [7:0] hs_val;
  logic [7:0] gpio_out;
  logic [7:0] pc_rd;
  logic [7:0] pa_rd;
  logic [7:0] pb_rd;
  logic [2:0] bsr_sel;
  logic       req_a;
  logic       req_b;

  // mode fields and host strobe ends
  always_comb begin
    mode_a  = mode_of_a(r.mode_word);
    mode_b  = mode_of_b(r.mode_word);
    a_in    = r.mode_word[`PPMC_CW_A_IN];
    cu_in   = r.mode_word[`PPMC_CW_CU_IN];
    b_in    = r.mode_word[`PPMC_CW_B_IN];
    cl_in   = r.mode_word[`PPMC_CW_CL_IN];
    wr_end  = r.wr_d & ~r.wr_s[1];
    rd_end  = r.rd_d & ~r.rd_s[1];
    pc_fall = r.pc_d & ~r.pc_s2;
    bsr_sel = r.cap_data[`PPMC_BSR_SEL_HI:`PPMC_BSR_SEL_LO];
  end

  // ownership of the third-port lines by handshake or plain use
  always_comb begin
    hs_mask  = 8'h00;
    hs_out   = 8'h00;
    hs_val   = 8'h00;
    gpio_out = {{4{~cu_in}}, {4{~cl_in}}};
    case (mode_a)
      PPMC_STROBED: begin
        hs_mask[`PPMC_PC_A_INTR] = 1'b1;
        hs_out[`PPMC_PC_A_INTR]  = 1'b1;
        if (a_in) begin
          hs_mask[`PPMC_PC_A_IBF] = 1'b1;
          hs_mask[`PPMC_PC_A_STB] = 1'b1;
          hs_out[`PPMC_PC_A_IBF]  = 1'b1;
        end else begin
          hs_mask[`PPMC_PC_A_OBF] = 1'b1;
          hs_mask[`PPMC_PC_A_ACK] = 1'b1;
          hs_out[`PPMC_PC_A_OBF]  = 1'b1;
        end
      end
      PPMC_BIDIR: begin
        hs_mask[`PPMC_PC_A_OBF:`PPMC_PC_A_INTR] = 5'h1f;
        hs_out[`PPMC_PC_A_OBF]  = 1'b1;
        hs_out[`PPMC_PC_A_IBF]  = 1'b1;
        hs_out[`PPMC_PC_A_INTR] = 1'b1;
      end
      default: begin
      end
    endcase
    if (mode_b == PPMC_STROBED) begin
      hs_mask[`PPMC_PC_B_STB:`PPMC_PC_B_INTR] = 3'h7;
      hs_out[`PPMC_PC_B_BUF]  = 1'b1;
      hs_out[`PPMC_PC_B_INTR] = 1'b1;
    end
    // handshake line levels, output-buffer-full lines active low, input-buffer-full lines active high
    hs_val[`PPMC_PC_A_OBF]  = ~hs[0].obf;
    hs_val[`PPMC_PC_A_IBF]  = hs[0].ibf;
    hs_val[`PPMC_PC_A_INTR] = hs[0].intr;
    hs_val[`PPMC_PC_B_BUF]  = b_in ? hs[1].ibf : ~hs[1].obf;
    hs_val[`PPMC_PC_B_INTR] = hs[1].intr;
  end

  // group links; enables of the requests live in third-port latch bits
  always_comb begin
    hs[0].en_in    = (mode_a == PPMC_BIDIR) || (mode_a == PPMC_STROBED && a_in);
    hs[0].en_out   = (mode_a == PPMC_BIDIR) || (mode_a == PPMC_STROBED && !a_in);
    hs[0].inte_in  = r.out_c[`PPMC_PC_A_STB];
    hs[0].inte_out = r.out_c[`PPMC_PC_A_ACK];
    hs[0].stb_fall = pc_fall[`PPMC_PC_A_STB];
    hs[0].ack_fall = pc_fall[`PPMC_PC_A_ACK];
    hs[0].rd_pulse = rd_end && r.cap_addr == `PPMC_OFS_FIRST;
    hs[0].wr_pulse = wr_end && r.cap_addr == `PPMC_OFS_FIRST;
    hs[0].pin_data = r.pa_s2;
    hs[1].en_in    = mode_b == PPMC_STROBED && b_in;
    hs[1].en_out   = mode_b == PPMC_STROBED && !b_in;
    hs[1].inte_in  = r.out_c[`PPMC_PC_B_STB];
    hs[1].inte_out = r.out_c[`PPMC_PC_B_STB];
    hs[1].stb_fall = pc_fall[`PPMC_PC_B_STB];
    hs[1].ack_fall = pc_fall[`PPMC_PC_B_STB];
    hs[1].rd_pulse = rd_end && r.cap_addr == `PPMC_OFS_SECOND;
    hs[1].wr_pulse = wr_end && r.cap_addr == `PPMC_OFS_SECOND;
    hs[1].pin_data = r.pb_s2;
  end

  // both handshake groups
  generate
    for (genvar g = 0; g < 2; g++) begin : g_grp
      ppmc_hs_group ppmc_hs_group_inst (
        .mclk (mclk),
        .nrst (nrst),
        .hs   (hs[g])
      );
    end
  endgenerate

  // read values of the three data ports
  always_comb begin
    if (mode_a == PPMC_BASIC) begin
      pa_rd = a_in ? r.pa_s2 : r.out_a;
    end else if (mode_a == PPMC_STROBED && !a_in) begin
      pa_rd = r.out_a;
    end else begin
      pa_rd = hs[0].lat;
    end
    if (mode_b == PPMC_STROBED && b_in) begin
      pb_rd = hs[1].lat;
    end else begin
      pb_rd = b_in ? r.pb_s2 : r.out_b;
    end
    // handshake inputs read back their enable bit, outputs their level
    for (int i = 0; i < 8; i++) begin
      if (hs_mask[i]) begin
        pc_rd[i] = hs_out[i] ? hs_val[i] : r.out_c[i];
      end else begin
        pc_rd[i] = gpio_out[i] ? r.out_c[i] : r.pc_s2[i];
      end
    end
  end

  // requests through the enable gates
  always_comb begin
    req_a = hs[0].intr & r.port_irq_en[`PPMC_EN_A_BIT];
    req_b = hs[1].intr & r.port_irq_en[`PPMC_EN_B_BIT];
  end

  // next state: synchronisers, host writes and reads, pin drive
  always_comb begin
    next_r         = r;
    next_r.wr_s    = {r.wr_s[0], ~host_wr_n};
    next_r.wr_d    = r.wr_s[1];
    next_r.rd_s    = {r.rd_s[0], ~host_rd_n};
    next_r.rd_d    = r.rd_s[1];
    next_r.addr_s1 = host_addr;
    next_r.addr_s2 = r.addr_s1;
    next_r.wdat_s1 = host_wdata;
    next_r.wdat_s2 = r.wdat_s1;
    next_r.pa_s1   = pa_in;
    next_r.pa_s2   = r.pa_s1;
    next_r.pb_s1   = pb_in;
    next_r.pb_s2   = r.pb_s1;
    next_r.pc_s1   = pc_in;
    next_r.pc_s2   = r.pc_s1;
    next_r.pc_d    = r.pc_s2;
    // follow address and data while a strobe is active, hold them after
    if (r.wr_s[1] || r.rd_s[1]) begin
      next_r.cap_addr = r.addr_s2;
      next_r.cap_data = r.wdat_s2;
    end
    // register writes at the end of the write strobe
    if (wr_end) begin
      case (r.cap_addr)
        `PPMC_OFS_FIRST: begin
          next_r.out_a = r.cap_data;
        end
        `PPMC_OFS_SECOND: begin
          next_r.out_b = r.cap_data;
        end
        `PPMC_OFS_THIRD: begin
          next_r.out_c = (r.out_c & hs_mask) | (r.cap_data & ~hs_mask);
        end
        `PPMC_OFS_MODE: begin
          if (r.cap_data[`PPMC_CW_FLAG]) begin
            next_r.mode_word = r.cap_data;
            next_r.out_a     = `PPMC_BYTE_ZERO;
            next_r.out_c     = `PPMC_BYTE_ZERO;
          end else begin
            next_r.out_c[bsr_sel] = r.cap_data[`PPMC_BSR_VAL];
          end
        end
        `PPMC_OFS_IRQ_EN: begin
          next_r.port_irq_en = r.cap_data[`PPMC_EN_B_BIT:`PPMC_EN_A_BIT];
        end
        `PPMC_OFS_IRQ_GATE: begin
          next_r.global_irq_enable = r.cap_data[`PPMC_GIE_BIT];
        end
        default: begin
        end
      endcase
    end
    // read data driven while the read strobe is seen
    next_r.host_rdata_oe = r.rd_s[1];
    case (r.addr_s2)
      `PPMC_OFS_FIRST:  next_r.host_rdata = pa_rd;
      `PPMC_OFS_SECOND: next_r.host_rdata = pb_rd;
      `PPMC_OFS_THIRD:  next_r.host_rdata = pc_rd;
      default:          next_r.host_rdata = `PPMC_BYTE_ZERO;
    endcase
    next_r.host_irq = r.global_irq_enable & (req_a | req_b);
    // first port drive: output modes, or bus turned while acknowledged
    next_r.pa_out = r.out_a;
    case (mode_a)
      PPMC_BASIC:   next_r.pa_oe = ~a_in;
      PPMC_STROBED: next_r.pa_oe = ~a_in;
      PPMC_BIDIR:   next_r.pa_oe = ~r.pc_s2[`PPMC_PC_A_ACK];
      default:      next_r.pa_oe = 1'b0;
    endcase
    next_r.pb_out = r.out_b;
    next_r.pb_oe  = ~b_in;
    // third port: handshake lines override the plain latch
    for (int i = 0; i < 8; i++) begin
      if (hs_mask[i]) begin
        next_r.pc_out[i] = hs_val[i];
        next_r.pc_oe[i]  = hs_out[i];
      end else begin
        next_r.pc_out[i] = r.out_c[i];
        next_r.pc_oe[i]  = gpio_out[i];
      end
    end
  end

  // one register for all core state, the handshake groups hold their own
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r           <= '0;
      r.mode_word <= `PPMC_MODE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign host_rdata    = r.host_rdata;
  assign host_rdata_oe = r.host_rdata_oe;
  assign host_irq      = r.host_irq;
  assign pa_out        = r.pa_out;
  assign pa_oe         = r.pa_oe;
  assign pb_out        = r.pb_out;
  assign pb_oe         = r.pb_oe;
  assign pc_out        = r.pc_out;
  assign pc_oe         = r.pc_oe;

endmodule // ppmc_core

// file: tb/ppmc_core_chk.sv
// checker for the parallel port core, watching only its ports
// assumes: host strobes held 3+ mclk with 8+ mclk gaps between them
`timescale 1ns/1ps
`include "ppmc_map.svh"
module ppmc_core_chk
  import ppmc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic       host_wr_n,
  input wire logic       host_rd_n,
  input wire logic [7:0] host_rdata,
  input wire logic       host_rdata_oe,
  input wire logic       host_irq,
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pa_out,
  input wire logic       pa_oe,
  input wire logic [7:0] pb_in,
  input wire logic [7:0] pb_out,
  input wire logic       pb_oe,
  input wire logic [7:0] pc_in,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe
);
  logic [4:0] wa, rd_addr;
  logic [7:0] wd, mode_seen;
  logic       wr_q, gie_seen;
  logic [1:0] en_seen;
  logic [2:0] off_cnt, noen_cnt, mode_age, wr_age;
  wire        wr_end = host_wr_n && !wr_q;
  wire        basic  = (mode_seen[6:5] == 2'h0) && !mode_seen[2];
  wire        cw_wr  = wr_end && (wa == `PPMC_OFS_MODE);

  // shadow of host writes, taken as each write strobe ends
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_q      <= 1'b1;
      wa        <= 5'h00;
      wd        <= 8'h00;
      rd_addr   <= 5'h00;
      mode_seen <= `PPMC_MODE_RESET;
      gie_seen  <= 1'b0;
      en_seen   <= 2'h0;
      off_cnt   <= 3'h0;
      noen_cnt  <= 3'h0;
      mode_age  <= 3'h0;
      wr_age    <= 3'h0;
    end else begin
      wr_q <= host_wr_n;
      if (!host_wr_n) begin
        wa <= host_addr;
        wd <= host_wdata;
      end
      if (!host_rd_n) rd_addr <= host_addr;
      if (cw_wr && wd[7]) mode_seen <= wd;
      if (wr_end && wa == `PPMC_OFS_IRQ_GATE) gie_seen <= wd[`PPMC_GIE_BIT];
      if (wr_end && wa == `PPMC_OFS_IRQ_EN) en_seen <= wd[1:0];
      off_cnt  <= gie_seen ? 3'h0 : off_cnt + {2'h0, off_cnt != 3'h7};
      noen_cnt <= (en_seen != 2'h0) ? 3'h0 : noen_cnt + {2'h0, noen_cnt != 3'h7};
      mode_age <= (cw_wr && wd[7]) ? 3'h0 : mode_age + {2'h0, mode_age != 3'h7};
      wr_age   <= (!host_wr_n || wr_end) ? 3'h0 : wr_age + {2'h0, wr_age != 3'h7};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_gate_off_quiet: assert property (off_cnt == 3'h7 |-> !host_irq)
    else $error("host interrupt while global enable clear");
  chk_port_en_quiet: assert property (noen_cnt == 3'h7 |-> !host_irq)
    else $error("host interrupt with both port enables clear");
  chk_basic_dirs: assert property (mode_age == 3'h7 && basic |->
    pa_oe == !mode_seen[4] && pb_oe == !mode_seen[1] &&
    pc_oe == {{4{!mode_seen[3]}}, {4{!mode_seen[0]}}})
    else $error("port directions differ from basic control word");
  chk_mode_clears: assert property (cw_wr && wd[7] && wd[6:5] == 2'h0 && !wd[2] |->
    ##[2:6] (pa_out == 8'h00 && pc_out == 8'h00))
    else $error("first or third output latch not cleared by mode write");
  chk_bit_write: assert property (cw_wr && !wd[7] && basic && pc_oe[wd[3:1]] |->
    ##[2:6] pc_out[wd[3:1]] == wd[0])
    else $error("single bit write did not reach third port");
  chk_out_follows: assert property (wr_end && wa == 5'h00 && basic && !mode_seen[4] |->
    ##[2:6] pa_out == wd)
    else $error("first port output did not take written data");
  chk_out_latched: assert property (wr_age == 3'h7 |-> $stable(pa_out))
    else $error("first port output changed without a write");
  chk_read_answer: assert property ($fell(host_rd_n) |-> ##[2:4] host_rdata_oe)
    else $error("read not answered in time");
  chk_read_idle: assert property (host_rd_n [*5] |-> !host_rdata_oe)
    else $error("read data driven with no read strobe");
  chk_unmapped_zero: assert property (host_rdata_oe && !host_rd_n && rd_addr > 5'h02 |->
    host_rdata == 8'h00)
    else $error("write-only or unmapped offset read nonzero");
endmodule // ppmc_core_chk

bind ppmc_core ppmc_core_chk ppmc_core_chk_inst (
  .mclk(mclk), .nrst(nrst), .host_addr(host_addr), .host_wdata(host_wdata),
  .host_wr_n(host_wr_n), .host_rd_n(host_rd_n), .host_rdata(host_rdata),
  .host_rdata_oe(host_rdata_oe), .host_irq(host_irq), .pa_in(pa_in), .pa_out(pa_out),
  .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in),
  .pc_out(pc_out), .pc_oe(pc_oe)
);

// file: tb/ppmc_pins_model.sv
// far-side digital lines of the three ports
// assumes: bench sets far-side levels and strobes on ext_a/ext_b/ext_c
`timescale 1ns/1ps
module ppmc_pins_model (
  input  wire logic [7:0] pa_out,
  input  wire logic       pa_oe,
  input  wire logic [7:0] pb_out,
  input  wire logic       pb_oe,
  input  wire logic [7:0] pc_out,
  input  wire logic [7:0] pc_oe,
  input  wire logic [7:0] ext_a,
  input  wire logic [7:0] ext_b,
  input  wire logic [7:0] ext_c,
  output logic [7:0]      pa_in,
  output logic [7:0]      pb_in,
  output logic [7:0]      pc_in
);
  // wire level: core drive wins, else the far side's level
  assign pa_in = pa_oe ? pa_out : ext_a;
  assign pb_in = pb_oe ? pb_out : ext_b;
  // handshake strobes and acknowledges travel on third port lines
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
endmodule // ppmc_pins_model

// file: tb/parallel_port_mode_control_test.sv
// self-checking bench for the parallel port core
// assumes: pins model closes the port lines, checker bound to the core
`timescale 1ns/1ps
`include "ppmc_map.svh"
module parallel_port_mode_control_test;
  logic       mclk, nrst, host_wr_n, host_rd_n, host_rdata_oe, host_irq, pa_oe, pb_oe;
  logic [4:0] host_addr;
  logic [7:0] host_wdata, host_rdata, ext_a, ext_b, ext_c;
  logic [7:0] pa_in, pa_out, pb_in, pb_out, pc_in, pc_out, pc_oe;
  int         err_count, n_tests, cycles;

  ppmc_core ppmc_core_inst (
    .mclk(mclk), .nrst(nrst), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr_n(host_wr_n), .host_rd_n(host_rd_n), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe), .host_irq(host_irq), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in),
    .pc_out(pc_out), .pc_oe(pc_oe));
  ppmc_pins_model ppmc_pins_model_inst (
    .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe), .pc_out(pc_out),
    .pc_oe(pc_oe), .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c), .pa_in(pa_in),
    .pb_in(pb_in), .pc_in(pc_in));

  // 40 MHz clock and hang limit
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  // host write: strobe low 4 cycles, address and data held past its end
  task automatic hwrite(input logic [4:0] a, input logic [7:0] d);
    host_addr <= a;
    host_wdata <= d;
    host_wr_n <= 1'b0;
    tick(4);
    host_wr_n <= 1'b1;
    tick(8);
  endtask
  task automatic hread(input logic [4:0] a, output logic [7:0] d);
    host_addr <= a;
    host_rd_n <= 1'b0;
    tick(5);
    @(negedge mclk);
    check({7'h00, host_rdata_oe}, 8'h01);
    d = host_rdata;
    @(posedge mclk);
    host_rd_n <= 1'b1;
    tick(8);
  endtask
  // far-side strobe or acknowledge pulse on one third-port line
  task automatic strobe(input int b);
    ext_c[b] <= 1'b0;
    tick(4);
    ext_c[b] <= 1'b1;
    tick(8);
  endtask

  task automatic t_basic_out();
    hwrite(`PPMC_OFS_MODE, 8'h80);
    hwrite(`PPMC_OFS_FIRST, 8'h12);
    hwrite(`PPMC_OFS_SECOND, 8'h34);
    hwrite(`PPMC_OFS_THIRD, 8'h56);
    check(pa_out, 8'h12);
    check(pb_out, 8'h34);
    check(pc_out, 8'h56);
    hwrite(`PPMC_OFS_MODE, 8'h80);
    check(pa_out, 8'h00);
    check(pc_out, 8'h00);
    $display("test basic_out done");
  endtask
  task automatic t_dirs();
    logic [7:0] w [6] = '{8'h80, 8'h90, 8'h88, 8'h82, 8'h81, 8'h9b};
    foreach (w[i]) begin
      hwrite(`PPMC_OFS_MODE, w[i]);
      check({6'h00, pa_oe, pb_oe}, {6'h00, ~w[i][4], ~w[i][1]});
      check(pc_oe, {{4{~w[i][3]}}, {4{~w[i][0]}}});
    end
    $display("test dirs done");
  endtask
  task automatic t_inputs();
    logic [7:0] d;
    ext_a <= 8'ha5;
    ext_b <= 8'h3c;
    ext_c <= 8'h96;
    hread(`PPMC_OFS_FIRST, d);
    check(d, 8'ha5);
    hread(`PPMC_OFS_SECOND, d);
    check(d, 8'h3c);
    hread(`PPMC_OFS_THIRD, d);
    check(d, 8'h96);
    ext_a <= 8'h5a;
    hread(`PPMC_OFS_FIRST, d);
    check(d, 8'h5a);
    hread(`PPMC_OFS_MODE, d);
    check(d, 8'h00);
    hread(5'h07, d);
    check(d, 8'h00);
    $display("test inputs done");
  endtask
  task automatic t_bitops();
    logic [7:0] m;
    hwrite(`PPMC_OFS_MODE, 8'h80);
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      hwrite(`PPMC_OFS_MODE, {4'h0, i[2:0], 1'b1});
      m[i] = 1'b1;
      check(pc_out, m);
    end
    for (int i = 0; i < 8; i++) begin
      hwrite(`PPMC_OFS_MODE, {4'h7, i[2:0], 1'b0});
      m[i] = 1'b0;
      check(pc_out, m);
    end
    $display("test bitops done");
  endtask
  task automatic t_irq();
    logic [7:0] d;
    ext_c <= 8'hff;
    hwrite(`PPMC_OFS_MODE, 8'hb0);
    hwrite(`PPMC_OFS_MODE, 8'h09);
    hwrite(`PPMC_OFS_IRQ_EN, 8'h01);
    hwrite(`PPMC_OFS_IRQ_GATE, 8'h00);
    ext_a <= 8'hc3;
    strobe(`PPMC_PC_A_STB);
    check({7'h00, host_irq}, 8'h00);
    hread(`PPMC_OFS_THIRD, d);
    check(d & 8'h38, 8'h38);
    hwrite(`PPMC_OFS_IRQ_GATE, 8'h04);
    check({7'h00, host_irq}, 8'h01);
    ext_a <= 8'h0f;
    hread(`PPMC_OFS_FIRST, d);
    check(d, 8'hc3);
    check({7'h00, host_irq}, 8'h00);
    hwrite(`PPMC_OFS_IRQ_EN, 8'h00);
    strobe(`PPMC_PC_A_STB);
    check({7'h00, host_irq}, 8'h00);
    hwrite(`PPMC_OFS_IRQ_EN, 8'h01);
    check({7'h00, host_irq}, 8'h01);
    hread(`PPMC_OFS_FIRST, d);
    check(d, 8'h0f);
    $display("test irq done");
  endtask
  task automatic t_bidir();
    logic [7:0] d;
    hwrite(`PPMC_OFS_MODE, 8'hc0);
    check({7'h00, pa_oe}, 8'h00);
    ext_c[`PPMC_PC_A_ACK] <= 1'b0;
    tick(6);
    check({7'h00, pa_oe}, 8'h01);
    ext_c[`PPMC_PC_A_ACK] <= 1'b1;
    tick(6);
    check({7'h00, pa_oe}, 8'h00);
    ext_a <= 8'h7e;
    strobe(`PPMC_PC_A_STB);
    hread(`PPMC_OFS_FIRST, d);
    check(d, 8'h7e);
    $display("test bidir done");
  endtask
  // second group strobed input, then first group strobed output
  task automatic t_strobe_io();
    logic [7:0] d;
    hwrite(`PPMC_OFS_MODE, 8'h86);
    hwrite(`PPMC_OFS_MODE, 8'h05);
    hwrite(`PPMC_OFS_IRQ_EN, 8'h02);
    ext_b <= 8'h69;
    strobe(`PPMC_PC_B_STB);
    check({7'h00, host_irq}, 8'h01);
    hread(`PPMC_OFS_THIRD, d);
    check(d & 8'h07, 8'h07);
    hread(`PPMC_OFS_SECOND, d);
    check(d, 8'h69);
    check({7'h00, host_irq}, 8'h00);
    hwrite(`PPMC_OFS_MODE, 8'ha0);
    hwrite(`PPMC_OFS_MODE, 8'h0d);
    hwrite(`PPMC_OFS_IRQ_EN, 8'h01);
    hwrite(`PPMC_OFS_FIRST, 8'h3c);
    check(pa_out, 8'h3c);
    check({7'h00, pc_out[`PPMC_PC_A_OBF]}, 8'h00);
    check({7'h00, host_irq}, 8'h00);
    strobe(`PPMC_PC_A_ACK);
    check({7'h00, pc_out[`PPMC_PC_A_OBF]}, 8'h01);
    check({7'h00, host_irq}, 8'h01);
    $display("test strobe_io done");
  endtask
  // mid-run reset: outputs quiet, then basic all-input mode again
  task automatic t_reset();
    logic [7:0] d;
    nrst <= 1'b0;
    tick(2);
    check({5'h00, pa_oe, pb_oe, host_irq}, 8'h00);
    check(pc_oe, 8'h00);
    nrst <= 1'b1;
    tick(2);
    check(pa_out, 8'h00);
    hread(`PPMC_OFS_FIRST, d);
    check(d, 8'h7e);
    check({7'h00, host_irq}, 8'h00);
    $display("test reset done");
  endtask

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    host_addr = 5'h00;
    host_wdata = 8'h00;
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
    ext_a = 8'h00;
    ext_b = 8'h00;
    ext_c = 8'hff;
    tick(5);
    nrst <= 1'b1;
    tick(2);
    t_basic_out();
    t_dirs();
    t_inputs();
    t_bitops();
    t_irq();
    t_bidir();
    t_strobe_io();
    t_reset();
    results();
  end
endmodule // parallel_port_mode_control_test
